// ===== src/dbs_top.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps

// Summary of operation
// - Breakpoint on final state when enabled.
// - With tracing, breakpoint waits for trace end.
// - View select picks the comparator window bank.
// - View select picks register at auxiliary slot.
// - Trace full after 64 lines since arming.
// - Trace full makes all 64 lines valid.
// - Writing arm one clears trace full.
// - Only power-on or arming clears trace full.
// - State flags follow sequencer transitions while armed.
// - Software disarm keeps last state flags.
// - Internal trigger end clears state flags.
// - Arming forces state flags to one.
module dbs_top (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 por,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire dbs_pkg::dbs_seq_t    seq_in,
  input  wire dbs_pkg::dbs_trace_t  trace_in,
  input  wire logic [3:0][63:0]     comp_bank,
  input  wire logic [3:0][7:0]      aux_reg,
  output dbs_pkg::dbs_win_wr_t      win_wr,
  output logic                      brk_req,
  output logic      [6:0]           trace_valid_lines,
  output logic                      session_armed,
  output logic                      irq
);
  import dbs_pkg::*;

  dbs_bus_state_t bus_state;
  dbs_bus_state_t next_bus_state;
  logic [7:0]     addr_idx;
  logic [7:0]     ctrl1;
  logic           trace_full_flag;
  logic [2:0]     sequencer_state_flags;
  logic [6:0]     trace_line_count;
  logic           brk_pending;
  logic [2:0]     irq_status;
  logic [2:0]     irq_enable;
  logic           accept;
  logic           wr_stb;
  logic [7:0]     wr_data;
  logic           arm_write;
  logic           disarm_write;
  logic           brk_fire;
  logic           full_set;
  logic [7:0]     rd_byte;
  logic [1:0]     comparator_view_select;
  logic           breakpoint_enable;

  // True when a register index falls inside the comparator window.
  function automatic logic in_window(input logic [7:0] idx);
    return (idx >= DBS_IDX_WIN_LO) && (idx <= DBS_IDX_WIN_HI);
  endfunction

  assign comparator_view_select = ctrl1[DBS_CTRL_VIEW_LSB +: 2];
  assign breakpoint_enable      = ctrl1[DBS_CTRL_BRK_BIT];
  assign session_armed          = ctrl1[DBS_CTRL_ARM_BIT];

  // Bus handshake: reads take one wait state so read data comes from a flop.
  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = (bus_state != DBS_BUS_READ_WAIT);
  assign hresp     = 1'b0;
  assign wr_stb    = (bus_state == DBS_BUS_WRITE);
  assign wr_data   = hwdata[7:0];

  // Software arm and disarm decoded from a control write.
  assign arm_write    = wr_stb && (addr_idx == DBS_IDX_CTRL1) && wr_data[DBS_CTRL_ARM_BIT];
  assign disarm_write = wr_stb && (addr_idx == DBS_IDX_CTRL1) && !wr_data[DBS_CTRL_ARM_BIT];

  // Next bus state after each edge.
  always_comb begin
    next_bus_state = DBS_BUS_IDLE;
    case (bus_state)
      DBS_BUS_READ_WAIT: begin
        next_bus_state = DBS_BUS_READ_DONE;
      end
      DBS_BUS_IDLE, DBS_BUS_WRITE, DBS_BUS_READ_DONE: begin
        if (accept) begin
          next_bus_state = hwrite ? DBS_BUS_WRITE : DBS_BUS_READ_WAIT;
        end
      end
      default: begin
        next_bus_state = DBS_BUS_IDLE;
      end
    endcase
  end

  // Bus state and latched address of the accepted transfer.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_state <= DBS_BUS_IDLE;
      addr_idx  <= 8'h00;
    end else begin
      bus_state <= next_bus_state;
      if (accept) begin
        addr_idx <= haddr[DBS_IDX_LSB +: 8];
      end
    end
  end

  // Read multiplexer; the window and auxiliary slot follow the view select.
  always_comb begin
    rd_byte = 8'h00;
    if (addr_idx == DBS_IDX_CTRL1) begin
      rd_byte = ctrl1;
    end else if (addr_idx == DBS_IDX_STATUS) begin
      rd_byte = {trace_full_flag, 4'h0, sequencer_state_flags};
    end else if (addr_idx == DBS_IDX_AUX) begin
      rd_byte = aux_reg[comparator_view_select];
    end else if (in_window(addr_idx)) begin
      rd_byte = comp_bank[comparator_view_select][addr_idx[2:0]*8 +: 8];
    end else if (addr_idx == DBS_IDX_IRQ_STAT) begin
      rd_byte = {5'h00, irq_status};
    end else if (addr_idx == DBS_IDX_IRQ_EN) begin
      rd_byte = {5'h00, irq_enable};
    end
  end

  // Read data is captured in the wait cycle and held until the next read.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_state == DBS_BUS_READ_WAIT) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // Writes into the comparator window or auxiliary slot go to their owners.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      win_wr <= '0;
    end else begin
      win_wr.valid    <= wr_stb && ((addr_idx == DBS_IDX_AUX) || in_window(addr_idx));
      win_wr.aux      <= (addr_idx == DBS_IDX_AUX);
      win_wr.bank     <= comparator_view_select;
      win_wr.byte_sel <= addr_idx[2:0];
      win_wr.data     <= wr_data;
    end
  end

  // Control one; an internal trigger end drops the arm bit.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl1 <= DBS_CTRL1_RST;
    end else if (wr_stb && addr_idx == DBS_IDX_CTRL1) begin
      ctrl1 <= wr_data;
    end else if (seq_in.trig_end && session_armed) begin
      ctrl1[DBS_CTRL_ARM_BIT] <= 1'b0;
    end
  end

  // Sequencer state flags follow the session.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sequencer_state_flags <= DBS_SSF_IDLE;
    end else if (arm_write) begin
      sequencer_state_flags <= DBS_SSF_ARMED;
    end else if (disarm_write) begin
      sequencer_state_flags <= sequencer_state_flags;
    end else if (session_armed && seq_in.trig_end) begin
      sequencer_state_flags <= DBS_SSF_IDLE;
    end else if (session_armed && seq_in.step) begin
      sequencer_state_flags <= seq_in.state;
    end
  end

  // Lines stored since arming, saturating at the buffer depth.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trace_line_count <= DBS_COUNT_RST;
    end else if (arm_write) begin
      trace_line_count <= DBS_COUNT_RST;
    end else if (trace_in.line_stored && trace_line_count != DBS_TRACE_LINES) begin
      trace_line_count <= trace_line_count + 7'h01;
    end
  end

  assign full_set = trace_in.line_stored && (trace_line_count == DBS_TRACE_LINES - 7'h01);

  // Trace full survives the system reset; only power-on or arming clears it.
  always_ff @(posedge sys_clk) begin
    if (por) begin
      trace_full_flag <= 1'b0;
    end else if (arm_write) begin
      trace_full_flag <= 1'b0;
    end else if (full_set) begin
      trace_full_flag <= 1'b1;
    end
  end

  // Count of valid trace lines shown to the reader.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trace_valid_lines <= DBS_COUNT_RST;
    end else begin
      trace_valid_lines <= trace_full_flag ? DBS_TRACE_LINES : trace_line_count;
    end
  end

  // Breakpoint request; with tracing it waits for the trace session to end.
  assign brk_fire = session_armed && breakpoint_enable &&
                    ((seq_in.final_reached && !trace_in.enabled) || (brk_pending && trace_in.done));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      brk_pending <= 1'b0;
      brk_req     <= 1'b0;
    end else begin
      brk_req <= brk_fire;
      if (arm_write || disarm_write || brk_fire) begin
        brk_pending <= 1'b0;
      end else if (session_armed && breakpoint_enable && seq_in.final_reached && trace_in.enabled) begin
        brk_pending <= 1'b1;
      end
    end
  end

  // Interrupt status: sticky, set wins over a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_status <= DBS_IRQ_RST;
      irq_enable <= DBS_IRQ_RST;
    end else begin
      if (wr_stb && addr_idx == DBS_IDX_IRQ_EN) begin
        irq_enable <= wr_data[2:0];
      end
      irq_status <= (irq_status & ~((wr_stb && addr_idx == DBS_IDX_IRQ_CLR) ? wr_data[2:0] : 3'h0))
                    | {session_armed && seq_in.trig_end, full_set && !trace_full_flag, brk_fire};
    end
  end

  // Level interrupt while any enabled status bit stands.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

endmodule

// ===== src/dbs_pkg.sv
package dbs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] DBS_IDX_CTRL1    = 8'h20;
  localparam logic [7:0] DBS_IDX_STATUS   = 8'h21;
  localparam logic [7:0] DBS_IDX_AUX      = 8'h27;
  localparam logic [7:0] DBS_IDX_WIN_LO   = 8'h28;
  localparam logic [7:0] DBS_IDX_WIN_HI   = 8'h2f;
  localparam logic [7:0] DBS_IDX_IRQ_STAT = 8'h30;
  localparam logic [7:0] DBS_IDX_IRQ_CLR  = 8'h31;
  localparam logic [7:0] DBS_IDX_IRQ_EN   = 8'h32;
  localparam int         DBS_IDX_LSB      = 2;

  // Field positions in debug control one and debug status.
  localparam int DBS_CTRL_ARM_BIT  = 7;
  localparam int DBS_CTRL_BRK_BIT  = 3;
  localparam int DBS_CTRL_VIEW_LSB = 0;
  localparam int DBS_STAT_FULL_BIT = 7;

  // Interrupt status bit positions.
  localparam int DBS_IRQ_BRK_BIT  = 0;
  localparam int DBS_IRQ_FULL_BIT = 1;
  localparam int DBS_IRQ_TRIG_BIT = 2;

  // Values after reset and forced values.
  localparam logic [7:0] DBS_CTRL1_RST   = 8'h00;
  localparam logic [2:0] DBS_IRQ_RST     = 3'h0;
  localparam logic [2:0] DBS_SSF_IDLE    = 3'h0;
  localparam logic [2:0] DBS_SSF_ARMED   = 3'h1;
  localparam logic [6:0] DBS_TRACE_LINES = 7'h40;
  localparam logic [6:0] DBS_COUNT_RST   = 7'h00;

  // Step reports from the rest of the state sequencer.
  typedef struct packed {
    logic       step;
    logic [2:0] state;
    logic       final_reached;
    logic       trig_end;
  } dbs_seq_t;

  // Events from the trace storage.
  typedef struct packed {
    logic line_stored;
    logic enabled;
    logic done;
  } dbs_trace_t;

  // Write passed on to the comparator window or the auxiliary register.
  typedef struct packed {
    logic       valid;
    logic       aux;
    logic [1:0] bank;
    logic [2:0] byte_sel;
    logic [7:0] data;
  } dbs_win_wr_t;

  typedef enum logic [1:0] {
    DBS_BUS_IDLE,
    DBS_BUS_WRITE,
    DBS_BUS_READ_WAIT,
    DBS_BUS_READ_DONE
  } dbs_bus_state_t;

endpackage

// ===== testbench/dbs_props.sv
`timescale 1ns/100ps
module dbs_props (
  input wire logic                 sys_clk,
  input wire logic                 reset,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire dbs_pkg::dbs_seq_t    seq_in,
  input wire dbs_pkg::dbs_trace_t  trace_in,
  input wire dbs_pkg::dbs_win_wr_t win_wr,
  input wire logic                 brk_req,
  input wire logic [6:0]           trace_valid_lines,
  input wire logic                 session_armed
);
  import dbs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic req;
  // An address phase taken by the slave.
  assign req = hsel && htrans[1] && hready;
  sequence s_rd; req && !hwrite; endsequence
  sequence s_ctrl_wr; req && hwrite && haddr[9:2] == DBS_IDX_CTRL1 ##1 hready; endsequence
  sequence s_win_wr; req && hwrite && haddr[9:2] >= DBS_IDX_WIN_LO && haddr[9:2] <= DBS_IDX_WIN_HI ##1 hready; endsequence
  property p_rd_wait; s_rd |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_arm_wr; s_ctrl_wr |=> session_armed == $past(hwdata[DBS_CTRL_ARM_BIT]); endproperty
  a_arm_wr: assert property (p_arm_wr) else $error("arm bit wrong");
  property p_win; s_win_wr |=> win_wr.valid && !win_wr.aux && win_wr.byte_sel == $past(haddr[4:2], 2); endproperty
  a_win: assert property (p_win) else $error("window write wrong");
  property p_brk_cause;
    brk_req |-> $past(session_armed && (seq_in.final_reached && !trace_in.enabled || trace_in.done));
  endproperty
  a_brk_cause: assert property (p_brk_cause) else $error("breakpoint without cause");
  property p_brk_wait; seq_in.final_reached && trace_in.enabled && !trace_in.done |=> !brk_req; endproperty
  a_brk_wait: assert property (p_brk_wait) else $error("breakpoint during trace");
  property p_brk_pulse; brk_req |=> !brk_req; endproperty
  a_brk_pulse: assert property (p_brk_pulse) else $error("breakpoint too long");
  property p_trig; seq_in.trig_end && session_armed |=> !session_armed; endproperty
  a_trig: assert property (p_trig) else $error("trigger end kept arm");
  property p_tvl; trace_valid_lines <= DBS_TRACE_LINES; endproperty
  a_tvl: assert property (p_tvl) else $error("valid lines above 64");
endmodule
bind dbs_top dbs_props u_dbs_props (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .seq_in, .trace_in, .win_wr, .brk_req, .trace_valid_lines, .session_armed);

// ===== testbench/dbs_core_model.sv
`timescale 1ns/100ps
module dbs_core_model (
  input wire logic sys_clk,
  input wire logic brk_req,
  output int       brk_count
);
  // The core counts every breakpoint request it sees; no reset clears it.
  initial brk_count = 0;
  always @(posedge sys_clk) begin
    if (brk_req === 1'b1) brk_count <= brk_count + 1;
  end
endmodule

// ===== testbench/dbs_top_tb_top.sv
`timescale 1ns/100ps
module dbs_top_tb_top;
  import dbs_pkg::*;
  logic             sys_clk, reset, por, hsel, hwrite, hready, hreadyout, hresp, brk_req, session_armed, irq;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [6:0]       tvl;
  dbs_seq_t         seq_in;
  dbs_trace_t       trace_in;
  dbs_win_wr_t      win_wr;
  logic [3:0][63:0] comp_bank;
  logic [3:0][7:0]  aux_reg;
  int               mismatches, total_checks, brk_count;
  // The single slave drives the bus ready.
  assign hready = hreadyout;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  dbs_top u_dbs_top (.sys_clk, .reset, .por, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .seq_in, .trace_in, .comp_bank, .aux_reg, .win_wr, .brk_req,
    .trace_valid_lines(tvl), .session_armed, .irq);
  dbs_core_model u_dbs_core_model (.sys_clk, .brk_req, .brk_count);
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One single word transfer; read data is taken at the final ready edge.
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rc(input string n, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  // One cycle of sequencer and trace events; the trace enable level stays.
  task sq(input logic [5:0] s, input logic [2:0] t);
    @(posedge sys_clk);
    seq_in <= dbs_seq_t'(s);
    trace_in <= dbs_trace_t'(t);
    @(posedge sys_clk);
    seq_in <= '0;
    trace_in <= dbs_trace_t'(t & 3'h2);
    repeat (3) @(posedge sys_clk);
  endtask
  task close_out;
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    close_out;
  end
  // Main sequence.
  initial begin
    {reset, por, hsel, hwrite, htrans, hsize, haddr, hwdata} = {2'b11, 4'h0, 3'h2, 64'h0};
    seq_in = '0;
    trace_in = '0;
    for (int v = 0; v < 4; v++) begin
      comp_bank[v] = 64'h0706050403020100 + 64'h1010101010101010 * v;
      aux_reg[v] = 8'ha0 + 8'(v);
    end
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    por <= 1'b0;
    rc("ctrl", 32'h80, 32'h0);
    ahb(1'b1, 32'h84, 32'hff);
    rc("stat ro", 32'h84, 32'h0);
    rc("unmapped", 32'hfc, 32'h0);
    chk("hresp", hresp, 1'b0);
    ahb(1'b1, 32'hc8, 32'h1);
    ahb(1'b1, 32'h80, 32'h88);
    rc("armed", 32'h84, 32'h1);
    sq(6'h2c, 3'h0);
    rc("step", 32'h84, 32'h3);
    sq(6'h02, 3'h0);
    chk("brk", brk_count, 1);
    chk("irq", irq, 1'b1);
    rc("irq stat", 32'hc0, 32'h1);
    ahb(1'b1, 32'hc4, 32'h1);
    ahb(1'b1, 32'hc8, 32'h0);
    chk("irq clr", irq, 1'b0);
    sq(6'h02, 3'h2);
    chk("brk trace", brk_count, 1);
    sq(6'h00, 3'h1);
    chk("brk done", brk_count, 2);
    chk("irq mask", irq, 1'b0);
    ahb(1'b1, 32'h80, 32'h08);
    rc("disarm", 32'h84, 32'h3);
    sq(6'h02, 3'h0);
    ahb(1'b1, 32'h80, 32'h80);
    sq(6'h02, 3'h0);
    chk("brk off", brk_count, 2);
    rc("rearm", 32'h84, 32'h1);
    sq(6'h01, 3'h0);
    rc("trig", 32'h84, 32'h0);
    ahb(1'b1, 32'h80, 32'h80);
    repeat (63) sq(6'h00, 3'h4);
    rc("63", 32'h84, 32'h1);
    chk("cnt", tvl, 63);
    repeat (4) sq(6'h00, 3'h4);
    rc("full", 32'h84, 32'h81);
    chk("all", tvl, 64);
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
    rc("keep", 32'h84, 32'h80);
    ahb(1'b1, 32'h80, 32'h80);
    rc("clr", 32'h84, 32'h1);
    for (int v = 0; v < 4; v++) begin
      ahb(1'b1, 32'h80, 32'(v));
      rc("aux", 32'h9c, 32'ha0 + 32'(v));
      rc("win0", 32'ha0, 32'(16 * v));
      rc("win7", 32'hbc, 32'(16 * v + 7));
      ahb(1'b1, 32'ha4, 32'h5a);
      @(negedge sys_clk);
      chk("win wr", 32'(win_wr), {17'h0, 1'b1, 1'b0, 2'(v), 3'h1, 8'h5a});
    end
    close_out;
  end
endmodule
